//--- hw/spwm_core.v
/*
 * spwm_core.v: standard single-output pulse-width modulator with three
 * selectable 8-bit period timers, prescaler, 10-bit double-buffered duty.
 * Assumes a host drives the configuration ports synchronously to mclk_in;
 * the sleep request is a pin and is synchronised here.
 */
`include "spwm_regs.vh"

module spwm_core #(
   parameter NTIMERS = 3
) (
   // clock and reset
   input  wire                   mclk_in,
   input  wire                   rst_in,
   // sleep request pin
   input  wire                   sleep_in,
   // period timer configuration, one field per timer
   input  wire [8*NTIMERS-1:0]   period_limit_reg_in,
   input  wire [2*NTIMERS-1:0]   timer_prescale_field_in,
   input  wire [NTIMERS-1:0]     timer_run_bit_in,
   input  wire [NTIMERS-1:0]     timer_flag_clear_in,
   // channel configuration
   input  wire [7:0]             duty_byte_reg_in,
   input  wire [7:0]             channel_control_reg_in,
   input  wire [1:0]             timer_select_field_in,
   input  wire                   pin_direction_bit_in,
   input  wire                   port_data_in,
   // status
   output wire [NTIMERS-1:0]     timer_match_flag_out,
   output wire [8*NTIMERS-1:0]   period_timer_count_out,
   output reg  [7:0]             active_duty_buffer_out,
   output reg  [1:0]             duty_low_latch_out,
   output reg                    pwm_level_out,
   // pin
   output reg                    pulse_output_pin_out,
   output reg                    pulse_output_pin_oe_n_out
);

   // sleep synchroniser: three stages, change counts when last two agree
   reg  [2:0]                    sleep_sync;
   reg                           asleep;

   always @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         sleep_sync <= 3'h0;
         asleep     <= 1'b0;
      end else begin
         sleep_sync <= {sleep_sync[1:0], sleep_in};
         if (sleep_sync[2] == sleep_sync[1])
            asleep <= sleep_sync[2];
      end
   end

   // per-timer prescaler, counter and match flag
   wire [NTIMERS-1:0]            step;
   wire [NTIMERS-1:0]            wrap;
   wire [10*NTIMERS-1:0]         next_tb_all;

   genvar g;
   generate
      for (g = 0; g < NTIMERS; g = g + 1) begin : tmr
         wire [1:0] ps = timer_prescale_field_in[2*g+1:2*g];
         // a count step ends after 4, 16 or 64 clocks
         wire [5:0] full = (ps == `SPWM_PS_DIV1) ? 6'h03 :
                           (ps == `SPWM_PS_DIV4) ? 6'h0F : 6'h3F;
         wire       run  = timer_run_bit_in[g] && !asleep;
         reg  [5:0] tick;
         reg  [7:0] cnt;
         reg        flag;
         reg  [7:0] cnt_q;
         wire [5:0] next_tick = !run ? tick : (tick == full) ? 6'h00 : tick + 6'h01;
         wire [7:0] next_cnt  = wrap[g] ? `SPWM_RST_COUNT :
                                step[g] ? cnt + 8'h01 : cnt;
         assign step[g] = run && (tick == full);
         assign wrap[g] = step[g] && (cnt == period_limit_reg_in[8*g+7:8*g]);
         // time base as it stands after this edge, so the level drops exactly
         // duty quarter-steps after the period start; low bits are phase or prescaler
         assign next_tb_all[10*g+:10] = {next_cnt,
                                         (ps == `SPWM_PS_DIV1) ? next_tick[1:0] :
                                         (ps == `SPWM_PS_DIV4) ? next_tick[3:2] :
                                         next_tick[5:4]};
         assign timer_match_flag_out[g]         = flag;
         assign period_timer_count_out[8*g+:8] = cnt_q;

         // postscaler is absent by design: period is set by the limit and prescaler only
         always @(posedge mclk_in or posedge rst_in) begin
            if (rst_in) begin
               tick  <= 6'h00;
               cnt   <= `SPWM_RST_COUNT;
               flag  <= 1'b0;
               cnt_q <= `SPWM_RST_COUNT;
            end else begin
               tick <= next_tick;
               cnt  <= next_cnt;
               // a match in the clearing cycle wins over the clear
               if (wrap[g])
                  flag <= 1'b1;
               else if (timer_flag_clear_in[g])
                  flag <= 1'b0;
               cnt_q <= cnt;
            end
         end
      end
   endgenerate

   // selected timer view
   wire [1:0] sel      = (timer_select_field_in < NTIMERS) ?
                         timer_select_field_in : `SPWM_RST_TSEL;
   wire       sel_wrap = wrap[sel];
   wire [9:0] next_tb  = next_tb_all[10*sel+:10];

   // channel mode decode
   wire       pwm_mode = (channel_control_reg_in[`SPWM_CTL_MODE_HI:`SPWM_CTL_MODE_HI-1]
                          == `SPWM_MODE_PWM_HI);
   wire       ctl_zero = (channel_control_reg_in == `SPWM_RST_CTL);
   wire [9:0] next_duty = {duty_byte_reg_in,
                           channel_control_reg_in[`SPWM_CTL_DLOW_HI:`SPWM_CTL_DLOW_LO]};
   wire [9:0] act_duty  = {active_duty_buffer_out, duty_low_latch_out};
   reg        next_level;

   // output level: set at period start, cleared on duty match
   always @* begin
      next_level = pwm_level_out;
      if (!pwm_mode)
         next_level = 1'b0;
      else if (sel_wrap)
         next_level = (next_duty != 10'h000);
      else if (next_tb == act_duty)
         next_level = 1'b0;
   end

   // duty double buffer and output register; nothing moves while asleep
   always @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         active_duty_buffer_out <= `SPWM_RST_DUTY;
         duty_low_latch_out     <= 2'h0;
         pwm_level_out          <= 1'b0;
      end else if (!asleep) begin
         // software has no write path to the buffer, so it reads only
         if (pwm_mode && sel_wrap) begin
            active_duty_buffer_out <= next_duty[9:2];
            duty_low_latch_out     <= next_duty[1:0];
         end
         pwm_level_out <= next_level;
      end
   end

   // pin driver: pulse only with direction bit cleared and module in control
   always @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         pulse_output_pin_out      <= 1'b0;
         pulse_output_pin_oe_n_out <= 1'b1;
      end else begin
         pulse_output_pin_oe_n_out <= pin_direction_bit_in;
         if (ctl_zero)
            pulse_output_pin_out <= port_data_in;
         else if (!asleep)
            pulse_output_pin_out <= next_level;
      end
   end

endmodule

//--- hw/spwm_regs.vh
/*
 * spwm_regs.vh: reset values, field positions and timing counts for the
 * standard pulse-width modulator.
 * Assumes inclusion once per compile unit; guarded against repeats.
 */
`ifndef SPWM_REGS_VH
`define SPWM_REGS_VH

// channel control register fields
`define SPWM_CTL_DLOW_HI     5
`define SPWM_CTL_DLOW_LO     4
`define SPWM_CTL_MODE_HI     3
`define SPWM_CTL_MODE_LO     0
// any mode value with both upper mode bits set selects pulse-width mode
`define SPWM_MODE_PWM_HI     2'h3

// reset values
`define SPWM_RST_PERIOD      8'hFF
`define SPWM_RST_DUTY        8'h00
`define SPWM_RST_CTL         8'h00
`define SPWM_RST_TSEL        2'h0
`define SPWM_RST_PRESCALE    2'h0
`define SPWM_RST_COUNT       8'h00

// prescale field encodings
`define SPWM_PS_DIV1         2'h0
`define SPWM_PS_DIV4         2'h1

// timer clocks per count step at 1:1 prescale: four oscillator periods
`define SPWM_QUARTERS        4

`endif

//--- testbench/spwm_core_assertions.sv
/*
 * checker for the pulse-width modulator core, timer 0 and pin side.
 * Assumes the bench holds limits and duty steady except across a reset.
 */
module spwm_core_assertions (
   input wire logic        mclk_in,
   input wire logic        rst_in,
   input wire logic        sleep_in,
   input wire logic [23:0] period_limit_reg_in,
   input wire logic [7:0]  duty_byte_reg_in,
   input wire logic [7:0]  channel_control_reg_in,
   input wire logic        port_data_in,
   input wire logic [2:0]  timer_match_flag_out,
   input wire logic [23:0] period_timer_count_out,
   input wire logic [7:0]  active_duty_buffer_out,
   input wire logic [1:0]  duty_low_latch_out,
   input wire logic        pwm_level_out,
   input wire logic        pulse_output_pin_out,
   input wire logic        pulse_output_pin_oe_n_out
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   // sleep must outlast the three-flop synchroniser before the freeze shows
   sequence asleep_s; sleep_in [*6]; endsequence
   sequence step_s; $changed(period_timer_count_out[7:0]); endsequence
   wrap_clear_a: assert property (step_s and ($past(period_timer_count_out[7:0]) ==
      $past(period_limit_reg_in[7:0])) |-> period_timer_count_out[7:0] == 8'h00)
      else $error("timer did not clear after limit");
   flag_on_wrap_a: assert property ($rose(timer_match_flag_out[0]) |-> ##[0:1]
      period_timer_count_out[7:0] == 8'h00) else $error("flag rose away from wrap");
   duty_latch_a: assert property ($changed(active_duty_buffer_out) |->
      active_duty_buffer_out == $past(duty_byte_reg_in)) else $error("bad duty latch");
   zero_duty_a: assert property ($rose(pwm_level_out) |->
      {active_duty_buffer_out, duty_low_latch_out} != 10'h000) else $error("zero duty rose");
   pin_follow_a: assert property ((channel_control_reg_in[3:2] == 2'h3 &&
      $stable(channel_control_reg_in)) |-> pulse_output_pin_out == pwm_level_out)
      else $error("pin differs from level");
   pin_release_a: assert property ((channel_control_reg_in == 8'h00 &&
      $past(channel_control_reg_in) == 8'h00) |-> pulse_output_pin_out == $past(port_data_in))
      else $error("pin not released");
   sleep_freeze_a: assert property (asleep_s |=> $stable(period_timer_count_out) &&
      $stable(pulse_output_pin_out)) else $error("state moved in sleep");
   reset_pin_a: assert property (disable iff (1'b0) rst_in |=>
      pulse_output_pin_oe_n_out && !pulse_output_pin_out) else $error("pin driven in reset");
endmodule

//--- testbench/spwm_load.sv
/*
 * external load on the pulse pin, with a pull-down.
 * Assumes the pin is undriven whenever the active-low enable is high.
 */
module spwm_load (
   input  wire logic pin_in,
   input  wire logic oe_n_in,
   output wire logic level_out
);
   timeunit 1ns;
   timeprecision 100ps;
   // a released pin sinks to the pull-down rather than keeping its last value
   assign level_out = oe_n_in ? 1'b0 : pin_in;
endmodule

//--- testbench/tb_spwm_core.sv
/*
 * self-checking bench for the pulse-width modulator core.
 * Assumes the load model and checker are compiled alongside the design.
 */
module tb_spwm_core;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk_in = 0, rst_in = 1, sleep_in = 0, dir = 1, port_d = 0, prev = 0;
   logic [23:0] lim = 0;
   logic [7:0]  duty = 0, ctl = 0;
   logic [5:0]  ps = 0;
   logic [1:0]  sel = 0;
   logic [2:0]  run = 0, fclr = 0;
   logic [24:0] c0 = 0;
   logic [31:0] q[$];
   wire  [2:0]  flag;
   wire  [23:0] cnt;
   wire  [7:0]  dbuf;
   wire  [1:0]  dlat;
   wire         lvl, pin, oen, load_lvl;
   int miscompares = 0, cmp_count = 0, per = 0, hi = 0;
   bit arm = 0, seen = 0;
   always #2.5 mclk_in = ~mclk_in;
   spwm_core dut (.mclk_in, .rst_in, .sleep_in, .period_limit_reg_in(lim),
      .timer_prescale_field_in(ps), .timer_run_bit_in(run), .timer_flag_clear_in(fclr),
      .duty_byte_reg_in(duty), .channel_control_reg_in(ctl), .timer_select_field_in(sel),
      .pin_direction_bit_in(dir), .port_data_in(port_d), .timer_match_flag_out(flag),
      .period_timer_count_out(cnt), .active_duty_buffer_out(dbuf),
      .duty_low_latch_out(dlat), .pwm_level_out(lvl), .pulse_output_pin_out(pin),
      .pulse_output_pin_oe_n_out(oen));
   spwm_load load (.pin_in(pin), .oe_n_in(oen), .level_out(load_lvl));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: seen %h expected %h", $time, got, exp);
      end
   endtask
   task close_out;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // measure one whole period per setting at the load, skipping the first after arming
   always @(negedge mclk_in) begin
      if (load_lvl && !prev) begin
         if (arm && seen && q.size() > 0) chk({per[15:0], hi[15:0]}, q.pop_front());
         seen = arm;
         per = 0;
         hi = 0;
      end
      if (rst_in) seen = 0;
      per++;
      hi += load_lvl;
      prev = load_lvl;
   end
   // every timer with every prescale; setup order kept, first flag not awaited
   initial begin
      int l, d, p, s;
      void'($urandom(32'hCDFB394D));
      repeat (3) @(posedge mclk_in);
      for (s = 0; s < 3; s++) for (p = 0; p < 3; p++) begin
         @(posedge mclk_in) #1 rst_in = 1;
         lim = $urandom & 24'h070707;
         l = lim[8*s+:8];
         d = 1 + $urandom_range(4 * l + 2); // duty stays below the period
         {duty, ctl} = {d[9:2], 2'h0, d[1:0], 4'hC};
         {sel, fclr, ps, run, dir} = {s[1:0], 3'h7, {3{p[1:0]}}, 3'h0, 1'b0};
         @(posedge mclk_in) #1 chk({oen, pin}, 2'h2);
         rst_in = 0;
         fclr = 3'h0;
         run = 3'h7;
         q.push_back({16'(4 * (l + 1) * (4 ** p)), 16'(d * (4 ** p))});
         arm = 1;
         for (int i = 0; i < 3000 && q.size() > 0; i++) @(posedge mclk_in);
         chk(q.size(), 0);
         chk(flag[s], 1);
         arm = 0;
      end
      @(posedge mclk_in) #1 sleep_in = 1;
      repeat (8) @(posedge mclk_in);
      #1 c0 = {cnt, pin};
      repeat (12) @(posedge mclk_in);
      #1 chk({cnt, pin}, c0);
      sleep_in = 0;
      ctl = 8'h00;
      repeat (8) @(posedge mclk_in) #1 port_d = $urandom;
      close_out;
   end
   // watchdog well beyond the longest sweep
   initial begin
      #150us;
      miscompares++;
      close_out;
   end
endmodule
bind spwm_core spwm_core_assertions chk_i (.mclk_in, .rst_in, .sleep_in,
   .period_limit_reg_in, .duty_byte_reg_in, .channel_control_reg_in, .port_data_in,
   .timer_match_flag_out, .period_timer_count_out, .active_duty_buffer_out,
   .duty_low_latch_out, .pwm_level_out, .pulse_output_pin_out, .pulse_output_pin_oe_n_out);
